/* File: pas_defs.vh */
// pas_defs.vh: offsets, field positions, reset values and timing counts
// of the pattern address sequencer.
// assumes a 250 MHz ref_clk and a 32-bit APB slave port.
`ifndef PAS_DEFS_VH
`define PAS_DEFS_VH

// register byte offsets
`define PAS_OFF_CTRL 8'h00
`define PAS_OFF_FIRST 8'h04
`define PAS_OFF_LAST 8'h08
`define PAS_OFF_PERIOD 8'h0C
`define PAS_OFF_CMD 8'h10
`define PAS_OFF_STATUS 8'h14
`define PAS_OFF_STB 8'h18

// control register fields
`define PAS_CTRL_MODE_LSB 0
`define PAS_CTRL_MODE_MSB 2
`define PAS_CTRL_GATE_EN 4
`define PAS_CTRL_STB_BRK 5
`define PAS_CTRL_STB_CLK 6

// command register bits, each a one-shot
`define PAS_CMD_RUN 0
`define PAS_CMD_STOP 1
`define PAS_CMD_BRK 2
`define PAS_CMD_NEXT 3
`define PAS_CMD_BACK 4
`define PAS_CMD_UPD 5

// strobe memory port: address in low bits, bit value here
`define PAS_STB_VAL 16
// status fields
`define PAS_STAT_STATE_LSB 16
`define PAS_STAT_TERR 20

// cycle modes
`define PAS_MODE_AUTO 3'h0
`define PAS_MODE_SINGLE 3'h1
`define PAS_MODE_GATED 3'h2
`define PAS_MODE_INIT_GATED 3'h3
`define PAS_MODE_INIT_AUTO 3'h4

// reset values
`define PAS_RST_CTRL 32'h00000000
`define PAS_RST_FIRST 14'h0000
`define PAS_RST_LAST 14'h0064
`define PAS_RST_PERIOD 32'h00000005

// timing
`define PAS_REF_HZ 250000000
`define PAS_FMAX_HZ 50000000
`define PAS_UPD_MS 50
`define PAS_MIN_PERIOD (`PAS_REF_HZ / `PAS_FMAX_HZ)
`define PAS_UPD_CYC (`PAS_REF_HZ / 1000 * `PAS_UPD_MS)

`endif

/* File: pas_sequencer.v */
// pas_sequencer.v: pattern address sequencer with APB registers, strobe
// break memory, internal clock divider and a two-entry output buffer.
// assumes ref_clk at 250 MHz and a gate pin from outside the clock domain.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "pas_defs.vh"

// Contract
// - auto mode wraps last to first forever
// - break steps forward/back, back stops at first (an init pass from zero can go below it)
// - run from break resumes at next address
// - stop then run restarts at first
// - single mode passes once, holds last
// - gated mode cycles while gate active
// - gate drop finishes cycle, stops at last
// - init modes start at zero, loop first-last
// - difference counter ends cycle exactly at last
// - last detection works at 50 MHz
// - strobe breaks halt at strobed addresses
// - strobe at start breaks immediately there
// - strobe lookup works at 50 MHz
// - strobe output selectable clock, errors ignored
// - status snapshot every 50 ms or command
module pas_sequencer #(
	parameter AW = 14,
	parameter UPD_CYCLES = `PAS_UPD_CYC
) (
	// clock and reset
	input wire ref_clk,
	input wire rstn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// gate pin
	input wire gate_pin,
	// pattern stream towards the device under test
	input wire pat_ready,
	output wire pat_valid,
	output wire [AW-1:0] pat_addr,
	output wire pat_strobe,
	// strobe pin: stored bit or internal clock
	output wire strobe_out
);

	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_WAIT = 4'h2;
	localparam [3:0] ST_RUN = 4'h4;
	localparam [3:0] ST_BRK = 4'h8;
	localparam DEPTH = 1 << AW;

	reg [31:0] ctrl_reg;
	reg [AW-1:0] first_reg;
	reg [AW-1:0] last_reg;
	reg [31:0] period_reg;
	reg [31:0] prdata_reg;
	reg pready_reg;
	reg pslverr_reg;
	reg [5:0] cmd_reg;
	reg stb_mem [0:DEPTH-1];
	reg [3:0] state_reg;
	reg [AW-1:0] addr_reg;
	reg [AW-1:0] diff_reg;
	reg [31:0] div_reg;
	reg tick_reg;
	reg pend_reg;
	reg phase_reg;
	reg strobe_out_reg;
	reg [2:0] gate_sync_reg;
	reg gate_lvl_reg;
	reg [31:0] upd_cnt_reg;
	reg [AW-1:0] snap_addr_reg;
	reg [3:0] snap_state_reg;
	reg hv_reg;
	reg [AW:0] hd_reg;
	reg sv_reg;
	reg [AW:0] sd_reg;

	wire [2:0] mode = ctrl_reg[`PAS_CTRL_MODE_MSB:`PAS_CTRL_MODE_LSB];
	wire gated_mode = (mode == `PAS_MODE_GATED) ||
		(mode == `PAS_MODE_INIT_GATED);
	wire init_mode = (mode == `PAS_MODE_INIT_GATED) ||
		(mode == `PAS_MODE_INIT_AUTO);
	wire gate_act = ctrl_reg[`PAS_CTRL_GATE_EN] & gate_lvl_reg;
	wire stb_brk_en = ctrl_reg[`PAS_CTRL_STB_BRK];
	wire access = psel & penable & pready_reg;
	wire wr_en = access & pwrite;
	wire timing_err = period_reg < `PAS_MIN_PERIOD;
	wire [31:0] period_eff = timing_err ? `PAS_MIN_PERIOD : period_reg;
	wire buf_in_ready = ~sv_reg;
	wire cur_stb = stb_mem[addr_reg];
	wire at_last = (diff_reg == {AW{1'b0}});
	wire step = pend_reg & buf_in_ready & (state_reg == ST_RUN);
	wire buf_pop = hv_reg & pat_ready;

	// decode used by the unmapped-address check; the read mux decodes with its own case
	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `PAS_OFF_CTRL) || (a == `PAS_OFF_FIRST) ||
				(a == `PAS_OFF_LAST) || (a == `PAS_OFF_PERIOD) ||
				(a == `PAS_OFF_CMD) || (a == `PAS_OFF_STATUS) ||
				(a == `PAS_OFF_STB);
		end
	endfunction

	// address after the current one; the difference counter marks the end
	function [AW-1:0] seq_next;
		input [AW-1:0] a;
		input last_hit;
		input [AW-1:0] first;
		begin
			seq_next = last_hit ? first : a + {{(AW-1){1'b0}}, 1'b1};
		end
	endfunction

	// apb: one wait-free access phase, answer registered at setup
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			pready_reg <= psel & ~penable;
			pslverr_reg <= psel & ~penable & ~mapped(paddr);
			if (psel & ~penable) begin
				case (paddr)
				`PAS_OFF_CTRL: prdata_reg <= ctrl_reg;
				`PAS_OFF_FIRST: prdata_reg <= {{(32-AW){1'b0}}, first_reg};
				`PAS_OFF_LAST: prdata_reg <= {{(32-AW){1'b0}}, last_reg};
				`PAS_OFF_PERIOD: prdata_reg <= period_reg;
				`PAS_OFF_STATUS: begin
					prdata_reg <= {{(32-AW){1'b0}}, snap_addr_reg};
					prdata_reg[`PAS_STAT_STATE_LSB+3:`PAS_STAT_STATE_LSB] <=
						snap_state_reg;
					prdata_reg[`PAS_STAT_TERR] <= timing_err;
				end
				default: prdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	// configuration writes; commands become one-cycle pulses
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= `PAS_RST_CTRL;
			first_reg <= `PAS_RST_FIRST;
			last_reg <= `PAS_RST_LAST;
			period_reg <= `PAS_RST_PERIOD;
			cmd_reg <= 6'h00;
		end else begin
			cmd_reg <= 6'h00;
			if (wr_en) begin
				case (paddr)
				`PAS_OFF_CTRL: ctrl_reg <= pwdata;
				`PAS_OFF_FIRST: first_reg <= pwdata[AW-1:0];
				`PAS_OFF_LAST: last_reg <= pwdata[AW-1:0];
				`PAS_OFF_PERIOD: period_reg <= pwdata;
				`PAS_OFF_CMD: cmd_reg <= pwdata[5:0];
				default: cmd_reg <= 6'h00;
				endcase
			end
		end
	end

	// strobe memory has no reset; software clears it before use
	always @(posedge ref_clk) begin
		if (wr_en && paddr == `PAS_OFF_STB) begin
			stb_mem[pwdata[AW-1:0]] <= pwdata[`PAS_STB_VAL];
		end
	end

	// gate pin: three flops, a change counts once stages two and three agree
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			gate_sync_reg <= 3'h0;
			gate_lvl_reg <= 1'b0;
		end else begin
			gate_sync_reg <= {gate_sync_reg[1:0], gate_pin};
			if (gate_sync_reg[1] == gate_sync_reg[2]) begin
				gate_lvl_reg <= gate_sync_reg[2];
			end
		end
	end

	// internal clock divider, clamped so the period never beats 50 MHz
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			div_reg <= 32'h00000000;
			tick_reg <= 1'b0;
			phase_reg <= 1'b0;
		end else begin
			tick_reg <= 1'b0;
			if (div_reg >= period_eff - 32'h00000001) begin
				div_reg <= 32'h00000000;
				tick_reg <= 1'b1;
			end else begin
				div_reg <= div_reg + 32'h00000001;
			end
			phase_reg <= (div_reg < (period_eff >> 1));
		end
	end

	// strobe pin in clock mode follows the divider alone, so a flagged
	// timing error cannot disturb it
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			strobe_out_reg <= 1'b0;
		end else begin
			strobe_out_reg <= ctrl_reg[`PAS_CTRL_STB_CLK] ? phase_reg :
				cur_stb;
		end
	end

	// one pending period; a stalled buffer holds it so no step is lost
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pend_reg <= 1'b0;
		end else if (state_reg != ST_RUN) begin
			pend_reg <= 1'b0;
		end else if (tick_reg) begin
			pend_reg <= 1'b1;
		end else if (step) begin
			pend_reg <= 1'b0;
		end
	end

	// sequencer control
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			addr_reg <= {AW{1'b0}};
			diff_reg <= {AW{1'b0}};
		end else begin
			case (state_reg)
			ST_IDLE: begin
				if (cmd_reg[`PAS_CMD_RUN]) begin
					// fresh start always; old break position dropped
					addr_reg <= init_mode ? {AW{1'b0}} : first_reg;
					diff_reg <= last_reg - (init_mode ? {AW{1'b0}} :
						first_reg);
					state_reg <= (gated_mode && !gate_act) ? ST_WAIT :
						ST_RUN;
				end
			end
			ST_WAIT: begin
				if (cmd_reg[`PAS_CMD_STOP]) begin
					state_reg <= ST_IDLE;
				end else if (cmd_reg[`PAS_CMD_BRK]) begin
					state_reg <= ST_BRK;
				end else if (gate_act) begin
					if (at_last) begin
						addr_reg <= first_reg;
						diff_reg <= last_reg - first_reg;
					end
					state_reg <= ST_RUN;
				end
			end
			ST_RUN: begin
				if (cmd_reg[`PAS_CMD_STOP]) begin
					state_reg <= ST_IDLE;
				end else if (cmd_reg[`PAS_CMD_BRK]) begin
					state_reg <= ST_BRK;
				end else if (step && stb_brk_en && cur_stb) begin
					state_reg <= ST_BRK;
				end else if (step) begin
					if (at_last && mode == `PAS_MODE_SINGLE) begin
						state_reg <= ST_IDLE;
					end else if (at_last && gated_mode && !gate_act) begin
						state_reg <= ST_WAIT;
					end else begin
						// counter reloads on wrap, so the end lands on last
						addr_reg <= seq_next(addr_reg, at_last, first_reg);
						diff_reg <= at_last ? last_reg - first_reg :
							diff_reg - {{(AW-1){1'b0}}, 1'b1};
					end
				end
			end
			ST_BRK: begin
				if (cmd_reg[`PAS_CMD_STOP]) begin
					state_reg <= ST_IDLE;
				end else if (cmd_reg[`PAS_CMD_RUN]) begin
					addr_reg <= seq_next(addr_reg, at_last, first_reg);
					diff_reg <= at_last ? last_reg - first_reg :
						diff_reg - {{(AW-1){1'b0}}, 1'b1};
					state_reg <= ST_RUN;
				end else if (cmd_reg[`PAS_CMD_NEXT] && !at_last) begin
					addr_reg <= addr_reg + {{(AW-1){1'b0}}, 1'b1};
					diff_reg <= diff_reg - {{(AW-1){1'b0}}, 1'b1};
				end else if (cmd_reg[`PAS_CMD_BACK] &&
						addr_reg != first_reg) begin
					addr_reg <= addr_reg - {{(AW-1){1'b0}}, 1'b1};
					diff_reg <= diff_reg + {{(AW-1){1'b0}}, 1'b1};
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// status snapshot: periodic unless the bus is busy, or on command
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			upd_cnt_reg <= 32'h00000000;
			snap_addr_reg <= {AW{1'b0}};
			snap_state_reg <= ST_IDLE;
		end else begin
			if (upd_cnt_reg >= UPD_CYCLES - 1) begin
				if (!psel) begin
					upd_cnt_reg <= 32'h00000000;
					snap_addr_reg <= addr_reg;
					snap_state_reg <= state_reg;
				end
			end else begin
				upd_cnt_reg <= upd_cnt_reg + 32'h00000001;
			end
			if (cmd_reg[`PAS_CMD_UPD]) begin
				snap_addr_reg <= addr_reg;
				snap_state_reg <= state_reg;
			end
		end
	end

	// two-entry skid buffer; its fullness stalls the sequencer via step
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hv_reg <= 1'b0;
			hd_reg <= {(AW+1){1'b0}};
			sv_reg <= 1'b0;
			sd_reg <= {(AW+1){1'b0}};
		end else if (!hv_reg || buf_pop) begin
			if (sv_reg) begin
				hv_reg <= 1'b1;
				hd_reg <= sd_reg;
				sv_reg <= 1'b0;
			end else begin
				hv_reg <= step;
				if (step) begin
					hd_reg <= {cur_stb, addr_reg};
				end
			end
		end else if (step) begin
			sv_reg <= 1'b1;
			sd_reg <= {cur_stb, addr_reg};
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign pat_valid = hv_reg;
	assign pat_addr = hd_reg[AW-1:0];
	assign pat_strobe = hd_reg[AW];
	assign strobe_out = strobe_out_reg;

endmodule // pas_sequencer
`default_nettype wire

/* File: pas_sequencer_properties.sv */
// pas_sequencer_properties.sv: port-level checks of the sequencer.
// assumes an APB master that holds its request until pready.
`timescale 1ns/100ps
`default_nettype none
`include "pas_defs.vh"

module pas_sequencer_properties #(
	parameter AW = 14
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pattern stream
	input wire logic pat_ready,
	input wire logic pat_valid,
	input wire logic [AW-1:0] pat_addr,
	input wire logic pat_strobe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// apb answers with zero wait states
	property p_setup_ready; psel && !penable |=> pready; endproperty
	a_setup_ready: assert property (p_setup_ready) else $error("no ready");
	property p_ready_access; pready |-> psel && penable; endproperty
	a_ready_access: assert property (p_ready_access) else $error("stray ready");
	property p_ready_once; pready |=> !pready; endproperty
	a_ready_once: assert property (p_ready_once) else $error("long ready");
	// error flag follows the offset decode
	property p_err_decode;
		pready |-> pslverr == (paddr > `PAS_OFF_STB || paddr[1:0] != 2'b00);
	endproperty
	a_err_decode: assert property (p_err_decode) else $error("bad decode");
	property p_err_zero; pslverr && !pwrite |-> prdata == 32'h00000000;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("error read data");
	property p_err_ready; pslverr |-> pready; endproperty
	a_err_ready: assert property (p_err_ready) else $error("error alone");
	// a stalled word must not change or vanish
	property p_valid_hold;
		pat_valid && !pat_ready |=> pat_valid && $stable(pat_addr)
			&& $stable(pat_strobe);
	endproperty
	a_valid_hold: assert property (p_valid_hold) else $error("word lost");
	property p_fell_take; $fell(pat_valid) |-> $past(pat_ready); endproperty
	a_fell_take: assert property (p_fell_take) else $error("word dropped");

	// main scenarios
	c_take: cover property (pat_valid && pat_ready);
	c_stall: cover property (pat_valid && !pat_ready);
	c_err: cover property (pready && pslverr);
endmodule // pas_sequencer_properties

bind pas_sequencer pas_sequencer_properties #(.AW(AW)) u_props (
	.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pat_ready(pat_ready), .pat_valid(pat_valid),
	.pat_addr(pat_addr), .pat_strobe(pat_strobe));
`default_nettype wire

/* File: pas_receiver_model.sv */
// pas_receiver_model.sv: device under test taking pattern words.
// assumes the bench supplies a per-cycle hold-off request.
`timescale 1ns/100ps
`default_nettype none

module pas_receiver_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// stall request from the bench
	input wire logic hold_off,
	// pattern stream
	output var logic pat_ready
);
	// ready changes only after an edge, so a word is never half taken
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			pat_ready <= 1'b0;
		else
			pat_ready <= !hold_off;
	end
endmodule // pas_receiver_model
`default_nettype wire

/* File: test_pattern_address_sequencer.sv */
// test_pattern_address_sequencer.sv: self-checking bench of the sequencer.
// assumes pas_defs.vh and the checker bind are compiled with it.
`timescale 1ns/100ps
`default_nettype none
`include "pas_defs.vh"

module test_pattern_address_sequencer;
	logic ref_clk, rstn, psel, penable, pwrite, gate_pin, hold_off, stall_all;
	logic [7:0] paddr;
	logic [31:0] pwdata, seed, rd;
	logic er, prev, stb_on;
	logic [13:0] q[$];
	logic [13:0] ls[5];
	logic [31:0] rv[4];
	integer fail_count, checked, i, k, n;
	wire [31:0] prdata;
	wire [13:0] pat_addr;
	wire pready, pslverr, pat_ready, pat_valid, pat_strobe, strobe_out;

	pas_sequencer #(.AW(14), .UPD_CYCLES(50)) u_dut (.ref_clk(ref_clk),
		.rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .gate_pin(gate_pin), .pat_ready(pat_ready),
		.pat_valid(pat_valid), .pat_addr(pat_addr), .pat_strobe(pat_strobe),
		.strobe_out(strobe_out));
	pas_receiver_model u_rx (.ref_clk(ref_clk), .rstn(rstn),
		.hold_off(hold_off), .pat_ready(pat_ready));

	always #2 ref_clk = ~ref_clk;

	function logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	// k-th emitted address; init modes run once from zero first
	function integer ex(input integer j, f, l, init);
		if (init && j <= l)
			ex = j;
		else
			ex = f + (init ? j - l - 1 : j) % (l - f + 1);
	endfunction

	// random stalls plus the capture of every word taken
	always @(posedge ref_clk) begin
		seed <= xs(seed);
		hold_off <= stall_all | seed[0];
		if (pat_valid === 1'b1 && pat_ready === 1'b1)
			q.push_back(pat_addr);
		// only 0, 1 and 4 carry a set strobe bit in the break scenario
		if (stb_on && pat_valid === 1'b1 && pat_ready === 1'b1)
			chk(pat_strobe, pat_addr inside {0, 1, 4});
	end

	task summarize;
		begin
			$display("checked %0d fail_count %0d", checked, fail_count);
			if (fail_count == 0 && checked > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		begin
			checked = checked + 1;
			if (s !== e) begin
				fail_count = fail_count + 1;
				$display("Error at %0t: saw %h expected %h", $time, s, e);
			end
		end
	endtask
	task timeout;
		begin
			fail_count = fail_count + 1;
			$display("Error at %0t: wait ran out", $time);
			summarize;
		end
	endtask
	// one apb transfer, then an idle cycle before the next setup
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		integer t;
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge ref_clk);
			penable <= 1'b1;
			t = 0;
			do begin
				@(posedge ref_clk);
				t = t + 1;
			end while (pready !== 1'b1 && t < 50);
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge ref_clk);
			if (t >= 50)
				timeout;
		end
	endtask
	task cmd(input integer b);
		apb(1'b1, `PAS_OFF_CMD, 32'h00000001 << b);
	endtask
	task stat_chk(input logic [3:0] s, input logic [13:0] a);
		begin
			// let a pending tick land before the snapshot is taken
			repeat (10) @(posedge ref_clk);
			cmd(`PAS_CMD_UPD);
			repeat (2) @(posedge ref_clk);
			apb(1'b0, `PAS_OFF_STATUS, 32'h00000000);
			chk(rd & 32'h000F3FFF, {12'h000, s, 2'b00, a});
		end
	endtask
	// program, let old words drain, then run from idle
	task run_mode(input logic [31:0] c, input logic [13:0] f, l);
		begin
			apb(1'b1, `PAS_OFF_CTRL, c);
			apb(1'b1, `PAS_OFF_FIRST, {18'h00000, f});
			apb(1'b1, `PAS_OFF_LAST, {18'h00000, l});
			repeat (30) @(posedge ref_clk);
			q.delete();
			cmd(`PAS_CMD_RUN);
		end
	endtask
	task waitq(input integer m);
		integer t;
		begin
			for (t = 0; t < 5000 && q.size() < m; t++)
				@(posedge ref_clk);
			if (q.size() < m)
				timeout;
		end
	endtask
	task seq(input integer m, f, l, init);
		integer j;
		for (j = 0; j < m; j++)
			chk(q[j], ex(j, f, l, init));
	endtask

	initial begin
		{ref_clk, rstn, psel, penable, pwrite, gate_pin, stall_all} = 7'h00;
		{hold_off, prev, stb_on, paddr, pwdata, fail_count, checked} = 0;
		seed = 32'h00009C40;
		ls = '{14'h0001, 14'h0002, 14'h0008, 14'h0200, 14'h0003};
		rv = '{`PAS_RST_CTRL, 32'h0, `PAS_RST_LAST, `PAS_RST_PERIOD};
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		for (i = 0; i < 4; i++) begin
			apb(1'b0, 8'(i * 4), 32'h00000000);
			chk(rd, rv[i]);
		end
		apb(1'b0, 8'h1C, 32'h00000000);
		chk(er, 32'h00000001);
		chk(rd, 32'h00000000);
		for (i = 0; i < 16; i++)
			apb(1'b1, `PAS_OFF_STB, i);
		// auto with a long stall that fills the buffer
		run_mode({29'h0, `PAS_MODE_AUTO}, 2, 6);
		stall_all <= 1'b1;
		repeat (60) @(posedge ref_clk);
		stall_all <= 1'b0;
		waitq(12);
		seq(12, 2, 6, 0);
		cmd(`PAS_CMD_STOP);
		repeat (30) @(posedge ref_clk);
		n = q.size();
		repeat (60) @(posedge ref_clk);
		chk(q.size(), n);
		// break, step back until held at first, step forward, resume, restart
		run_mode({29'h0, `PAS_MODE_AUTO}, 2, 6);
		waitq(3);
		cmd(`PAS_CMD_BRK);
		for (i = 0; i < 6; i++)
			cmd(`PAS_CMD_BACK);
		stat_chk(4'h8, 2);
		cmd(`PAS_CMD_NEXT);
		cmd(`PAS_CMD_NEXT);
		stat_chk(4'h8, 4);
		repeat (30) @(posedge ref_clk);
		q.delete();
		cmd(`PAS_CMD_RUN);
		waitq(1);
		chk(q[0], 5);
		cmd(`PAS_CMD_STOP);
		repeat (30) @(posedge ref_clk);
		q.delete();
		cmd(`PAS_CMD_RUN);
		waitq(1);
		chk(q[0], 2);
		cmd(`PAS_CMD_STOP);
		// single passes of several lengths, last one random
		ls[4] = 14'h0003 + {9'h000, seed[4:0]};
		for (k = 0; k < 5; k++) begin
			run_mode({29'h0, `PAS_MODE_SINGLE}, 0, ls[k]);
			waitq(ls[k] + 1);
			repeat (80) @(posedge ref_clk);
			chk(q.size(), ls[k] + 1);
			seq(ls[k] + 1, 0, ls[k], 0);
		end
		apb(1'b0, `PAS_OFF_STATUS, 32'h00000000);
		chk(rd & 32'h000F3FFF, {16'h0001, 2'b00, ls[4]});
		// gated: nothing before the gate, whole cycles after it drops
		run_mode({27'h2, `PAS_MODE_GATED}, 2, 6);
		repeat (60) @(posedge ref_clk);
		chk(q.size(), 0);
		gate_pin <= 1'b1;
		waitq(8);
		gate_pin <= 1'b0;
		repeat (100) @(posedge ref_clk);
		seq(q.size(), 2, 6, 0);
		chk(q.size() % 5, 0);
		chk(q[$], 14'h0006);
		// a run only restarts from idle, so leave the gated wait first
		cmd(`PAS_CMD_STOP);
		gate_pin <= 1'b1;
		run_mode({27'h2, `PAS_MODE_INIT_GATED}, 2, 6);
		waitq(12);
		gate_pin <= 1'b0;
		repeat (100) @(posedge ref_clk);
		seq(q.size(), 2, 6, 1);
		chk(q[$], 6);
		cmd(`PAS_CMD_STOP);
		// gate enabled but low: init auto must start anyway
		run_mode({27'h2, `PAS_MODE_INIT_AUTO}, 2, 6);
		waitq(12);
		seq(12, 2, 6, 1);
		cmd(`PAS_CMD_STOP);
		// strobe breaks at 0, 1 and 4 within 0..7
		for (i = 0; i < 3; i++)
			apb(1'b1, `PAS_OFF_STB, 32'h00010000 | (i * i));
		run_mode({27'h4, `PAS_MODE_AUTO}, 0, 7);
		stat_chk(4'h8, 0);
		stb_on = 1'b1;
		for (i = 0; i < 3; i++) begin
			cmd(`PAS_CMD_RUN);
			repeat (100) @(posedge ref_clk);
			stat_chk(4'h8, (i == 2) ? 0 : (i * 3 + 1));
		end
		stb_on = 1'b0;
		// too short a period flags an error, strobe clock stays at 5
		apb(1'b1, `PAS_OFF_PERIOD, 32'h00000002);
		run_mode({27'h8, `PAS_MODE_AUTO}, 2, 6);
		apb(1'b0, `PAS_OFF_STATUS, 32'h00000000);
		chk(rd[20], 1);
		n = 0;
		// seed the edge detector with the pin's real level, not a guess
		@(posedge ref_clk);
		prev = strobe_out;
		for (i = 0; i < 100; i++) begin
			@(posedge ref_clk);
			if (strobe_out === 1'b1 && prev === 1'b0)
				n = n + 1;
			prev = strobe_out;
		end
		chk(n, 20);
		summarize;
	end
endmodule // test_pattern_address_sequencer
`default_nettype wire
